/* File: shared/psc_consts.svh */
// constants of the passive serial configuration loader: offsets, fields,
// reset values and timing figures.
// assumes inclusion by bare name from files that need them.
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// clock rate and documented times
`define PSC_CLK_KHZ 50000
`define PSC_POR_LONG_MS 100
`define PSC_POR_SHORT_MS 12
`define PSC_OSC_KHZ 10000
`define PSC_INIT_CYCLES 299

// apb register byte offsets
`define PSC_OFS_CTRL 12'h000
`define PSC_OFS_IMAGE_BITS 12'h004
`define PSC_OFS_STATUS 12'h008
`define PSC_OFS_BIT_COUNT 12'h00C

// control fields
`define PSC_CTRL_USRCLK 0
`define PSC_CTRL_CABLE 1

// status fields
`define PSC_STAT_ERR 3
`define PSC_STAT_DONE 4

// reset values
`define PSC_CTRL_RST 2'h2
`define PSC_IMAGE_BITS_RST 32'h0000_0040
`define PSC_SYNC_PATTERN 8'hA5

`endif

/* File: shared/psc_pkg.sv */
// types of the passive serial configuration loader.
// assumes nothing of its surroundings.
package psc_pkg;

  // stages, gray coded along por-reset-config-wait-init-user
  typedef enum logic [2:0] {
    psc_st_por = 3'h0,
    psc_st_reset = 3'h1,
    psc_st_config = 3'h3,
    psc_st_done_wait = 3'h2,
    psc_st_init = 3'h6,
    psc_st_user = 3'h7,
    psc_st_error = 3'h5
  } psc_state_t;

endpackage

/* File: logic/psc_sync.sv */
// two-flop synchroniser bank with rising edge detect on each bit.
// assumes asynchronous inputs and one clock domain.
`timescale 1ns/1ps
`default_nettype none

module psc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // asynchronous levels
  input wire logic [W-1:0] async_i,
  // synchronised outputs
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // s1 feeds only s2, so metastability never reaches logic
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // edges are judged between the second and third flops
  assign level_o = s2_r;
  assign rise_o = s2_r & ~s3_r;

endmodule
`default_nettype wire

/* File: logic/psc_loader.sv */
// passive serial configuration loader: power-on delay, reset, serial
// load, initialization, error halt, chain hand-over, apb status/control.
// assumes pins arrive asynchronously and open-drain lines are resolved
// outside from the *_oe_o enables with external pull-ups.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.svh"

// What this block does
// - power-on delay 100 ms or 12 ms
// - during power-on hold status low, io off
// - user io stay off until user mode
// - weak pull-ups follow the pull-up select pin outside power-on and user mode
// - stages go reset, configuration, initialization
// - stay in reset while request or status low
// - request high releases the status line
// - data accepted only after status released
// - host clocks until completion line high
// - cable load ignores user start-up clock option
// - chain enable in low, out feeds next
// - shared completion line starts init together
// - shared status line halts whole chain
// - error pulls status low, chain resets
// - init clock internal or user start-up clock
module psc_loader #(
  parameter int POR_LONG_CYC = `PSC_POR_LONG_MS * `PSC_CLK_KHZ,
  parameter int POR_SHORT_CYC = `PSC_POR_SHORT_MS * `PSC_CLK_KHZ,
  parameter int POR_W = 23,
  parameter int INIT_CYC = `PSC_INIT_CYCLES,
  parameter logic [7:0] SYNC_PATTERN = `PSC_SYNC_PATTERN
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  // straps
  input wire logic reset_delay_select_i,
  input wire logic weak_pullup_select_b_i,
  // configuration request and shared open-drain lines
  input wire logic config_request_line_b_i,
  input wire logic config_status_line_b_i,
  output logic config_status_line_b_o,
  output logic config_status_line_b_oe_o,
  input wire logic load_complete_line_i,
  output logic load_complete_line_o,
  output logic load_complete_line_oe_o,
  // serial stream and chain
  input wire logic config_data_clock_i,
  input wire logic serial_config_data_i,
  input wire logic chain_enable_in_b_i,
  output logic chain_enable_out_b_o,
  input wire logic user_startup_clock_i,
  // device side
  output logic user_io_enable_o,
  output logic weak_pullup_en_o,
  output var psc_pkg::psc_state_t stage_o
);
  import psc_pkg::*;

  localparam int OSC_DIV = `PSC_CLK_KHZ / `PSC_OSC_KHZ;
  localparam logic [2:0] OSC_LAST = 3'(OSC_DIV - 1);
  localparam logic [8:0] INIT_LAST = 9'(INIT_CYC - 1);

  psc_state_t st_r, st_nxt;
  logic [8:0] sync_lvl, sync_rise;
  logic dly_sel_s, pu_sel_b_s, req_s, stat_s, done_s;
  logic data_clk_rise, data_s, chain_b_s, uclk_rise;
  logic [POR_W-1:0] por_cnt_r, por_lim;
  logic por_done;
  logic [31:0] bit_cnt_r, image_bits_r;
  logic [7:0] shift_r;
  logic [2:0] osc_cnt_r;
  logic [8:0] init_cnt_r;
  logic [1:0] ctrl_r;
  logic err_r;
  logic bit_take, last_bit, sync_bad, chain_abort;
  logic osc_tick, use_user, init_tick;
  logic stat_oe_r, done_oe_r, chain_b_r, io_en_r, pu_en_r, od_low_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, rd_data;
  logic apb_setup, apb_wr, hit_ctrl, hit_img, hit_stat, hit_cnt, hit_any;

  // address match, used once per register
  function automatic logic psc_hit(input logic [11:0] a,
                                   input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // every pin passes two flops before any logic sees it
  psc_sync #(.W(9)) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i({user_startup_clock_i, chain_enable_in_b_i,
              serial_config_data_i, config_data_clock_i,
              load_complete_line_i, config_status_line_b_i,
              config_request_line_b_i, weak_pullup_select_b_i,
              reset_delay_select_i}),
    .level_o(sync_lvl),
    .rise_o(sync_rise)
  );

  // named views of the synchronised pins
  assign dly_sel_s = sync_lvl[0];
  assign pu_sel_b_s = sync_lvl[1];
  assign req_s = sync_lvl[2];
  assign stat_s = sync_lvl[3];
  assign done_s = sync_lvl[4];
  assign data_clk_rise = sync_rise[5];
  assign data_s = sync_lvl[6];
  assign chain_b_s = sync_lvl[7];
  assign uclk_rise = sync_rise[8];

  // power-on delay length follows the select strap
  assign por_lim = dly_sel_s ? POR_W'(POR_SHORT_CYC - 1)
                             : POR_W'(POR_LONG_CYC - 1);
  assign por_done = (por_cnt_r >= por_lim);

  // bits are taken only in the configuration stage with chain enabled
  assign bit_take = (st_r == psc_st_config) && data_clk_rise
                    && !chain_b_s;
  assign last_bit = bit_take
                    && ((bit_cnt_r + 32'h1) == image_bits_r);
  assign sync_bad = bit_take && (bit_cnt_r == 32'h7)
                    && ({shift_r[6:0], data_s} != SYNC_PATTERN);
  // another device pulling status low halts this one too
  assign chain_abort = !stat_s && ((st_r == psc_st_config)
                       || (st_r == psc_st_done_wait)
                       || (st_r == psc_st_init));

  // init clock: internal divider, or user clock when allowed
  assign osc_tick = (osc_cnt_r == OSC_LAST);
  assign use_user = ctrl_r[`PSC_CTRL_USRCLK]
                    && !ctrl_r[`PSC_CTRL_CABLE];
  assign init_tick = use_user ? uclk_rise : osc_tick;

  // stage sequencing
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      psc_st_por: if (por_done) st_nxt = psc_st_reset;
      psc_st_reset: begin
        if (req_s && stat_s) st_nxt = psc_st_config;
      end
      psc_st_config: begin
        if (sync_bad) st_nxt = psc_st_error;
        else if (last_bit) st_nxt = psc_st_done_wait;
      end
      psc_st_done_wait: if (done_s) st_nxt = psc_st_init;
      psc_st_init: begin
        if (init_tick && init_cnt_r == INIT_LAST) st_nxt = psc_st_user;
      end
      psc_st_user: st_nxt = psc_st_user;
      psc_st_error: st_nxt = psc_st_error; // host must restart
      default: st_nxt = psc_st_por; // code 3'h4 is illegal
    endcase
    if (st_r != psc_st_por && !req_s) begin
      st_nxt = psc_st_reset;
    end else if (chain_abort) begin
      st_nxt = psc_st_reset;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) st_r <= psc_st_por;
    else st_r <= st_nxt;
  end

  // power-on counter runs only while in the power-on stage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) por_cnt_r <= '0;
    else if (st_r == psc_st_por && !por_done) begin
      por_cnt_r <= por_cnt_r + POR_W'(1);
    end
  end

  // serial bit counter and shift register, cleared in reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt_r <= '0;
      shift_r <= '0;
    end else if (st_r == psc_st_reset) begin
      bit_cnt_r <= '0;
      shift_r <= '0;
    end else if (bit_take) begin
      bit_cnt_r <= bit_cnt_r + 32'h1;
      shift_r <= {shift_r[6:0], data_s};
    end
  end

  // free-running internal oscillator stand-in
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) osc_cnt_r <= '0;
    else osc_cnt_r <= osc_tick ? 3'h0 : osc_cnt_r + 3'h1;
  end

  // initialization cycle counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) init_cnt_r <= '0;
    else if (st_r != psc_st_init) init_cnt_r <= '0;
    else if (init_tick) init_cnt_r <= init_cnt_r + 9'h1;
  end

  // sticky error flag; a new error beats the restart clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) err_r <= 1'b0;
    else err_r <= sync_bad || (err_r && req_s);
  end

  // pin outputs registered from the next stage so they stay glitch free
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_oe_r <= 1'b1;
      done_oe_r <= 1'b1;
      chain_b_r <= 1'b1;
      io_en_r <= 1'b0;
      pu_en_r <= 1'b0;
      od_low_r <= 1'b0;
    end else begin
      stat_oe_r <= (st_nxt == psc_st_por) || (st_nxt == psc_st_error)
                   || (st_nxt == psc_st_reset && !req_s);
      done_oe_r <= (st_nxt == psc_st_por) || (st_nxt == psc_st_reset)
                   || (st_nxt == psc_st_config)
                   || (st_nxt == psc_st_error);
      chain_b_r <= !((st_nxt == psc_st_done_wait)
                   || (st_nxt == psc_st_init)
                   || (st_nxt == psc_st_user));
      io_en_r <= (st_nxt == psc_st_user);
      pu_en_r <= !pu_sel_b_s && (st_nxt != psc_st_por)
                 && (st_nxt != psc_st_user);
      od_low_r <= 1'b0; // open-drain lines only ever pull low
    end
  end

  // apb decode: one wait-free access phase, read data prepared in setup
  assign apb_setup = psel_i && !penable_i;
  assign apb_wr = psel_i && penable_i && pready_r && pwrite_i;
  assign hit_ctrl = psc_hit(paddr_i, `PSC_OFS_CTRL);
  assign hit_img = psc_hit(paddr_i, `PSC_OFS_IMAGE_BITS);
  assign hit_stat = psc_hit(paddr_i, `PSC_OFS_STATUS);
  assign hit_cnt = psc_hit(paddr_i, `PSC_OFS_BIT_COUNT);
  assign hit_any = hit_ctrl || hit_img || hit_stat || hit_cnt;
  assign rd_data = hit_ctrl ? {30'h0, ctrl_r}
                 : hit_img ? image_bits_r
                 : hit_stat ? {27'h0, done_s, err_r, st_r}
                 : hit_cnt ? bit_cnt_r : 32'h0;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= apb_setup;
      pslverr_r <= apb_setup && !hit_any;
      prdata_r <= (apb_setup && !pwrite_i) ? rd_data : 32'h0;
    end
  end

  // writable registers; status and count are read only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= `PSC_CTRL_RST;
      image_bits_r <= `PSC_IMAGE_BITS_RST;
    end else if (apb_wr && hit_ctrl) begin
      ctrl_r <= pwdata_i[1:0];
    end else if (apb_wr && hit_img) begin
      image_bits_r <= pwdata_i;
    end
  end

  // every output straight from a flop
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign prdata_o = prdata_r;
  assign config_status_line_b_o = od_low_r;
  assign config_status_line_b_oe_o = stat_oe_r;
  assign load_complete_line_o = od_low_r;
  assign load_complete_line_oe_o = done_oe_r;
  assign chain_enable_out_b_o = chain_b_r;
  assign user_io_enable_o = io_en_r;
  assign weak_pullup_en_o = pu_en_r;
  assign stage_o = st_r;

  // checks on the stage machine and pins
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_por_status_low: assert property (
    st_r == psc_st_por |-> stat_oe_r && !io_en_r)
    else $error("status not held low during power-on");
  a_io_tristate: assert property (
    st_r != psc_st_user |-> !user_io_enable_o)
    else $error("user io enabled before user mode");
  a_pullup_off: assert property (
    pu_sel_b_s |=> !weak_pullup_en_o)
    else $error("pull-ups on while deselected");
  a_stage_order: assert property (
    st_r == psc_st_init && $past(st_r) != psc_st_init
    |-> $past(st_r) == psc_st_done_wait)
    else $error("init entered out of order");
  a_reset_hold: assert property (
    st_r == psc_st_reset && (!req_s || !stat_s) |=> st_r == psc_st_reset)
    else $error("left reset while request or status low");
  a_status_release: assert property (
    st_r == psc_st_reset && req_s |=> !config_status_line_b_oe_o)
    else $error("status not released after request high");
  a_no_early_data: assert property (
    st_r != psc_st_config |=> $stable(bit_cnt_r) || bit_cnt_r == 32'h0)
    else $error("bit counted outside configuration");
  a_sample_edge: assert property (
    bit_take && !last_bit && !sync_bad
    |=> bit_cnt_r == $past(bit_cnt_r) + 32'h1)
    else $error("data clock edge not sampled");
  a_chain_out: assert property (
    last_bit && req_s && !chain_abort |=> !chain_enable_out_b_o
    ##1 st_r == psc_st_done_wait || !req_s)
    else $error("chain enable out not given after last bit");
  a_error_halt: assert property (
    sync_bad && req_s && stat_s |=> st_r == psc_st_error && stat_oe_r)
    else $error("error did not pull status low");
  a_done_start: assert property (
    st_r == psc_st_done_wait && done_s && req_s && stat_s
    |=> st_r == psc_st_init)
    else $error("init not started on completion line");

  c_user_mode: cover property (st_r == psc_st_init ##1 st_r == psc_st_user);
  c_error: cover property (st_r == psc_st_config ##1 st_r == psc_st_error);
  c_chain_wait: cover property (st_r == psc_st_done_wait && !done_s);

endmodule
`default_nettype wire

/* File: tb/psc_host_model.sv */
// cable host model: pulses the request line, waits for the status line to
// be released, then clocks an image out msb first until completion rises.
// assumes clk_i is the bench clock; one data clock lasts 8 clk cycles.
`timescale 1ns/1ps
`default_nettype none

module psc_host_model (
  // bench clock
  input wire logic clk_i,
  // resolved shared lines
  input wire logic status_line_i,
  input wire logic complete_line_i,
  // cable outputs
  output logic request_b_o,
  output logic data_clk_o,
  output logic data_o
);
  // request held low at power-up so the device waits in reset
  initial begin
    request_b_o = 1'b0;
    data_clk_o = 1'b0;
    data_o = 1'b1;
  end

  // restart is manual: a failed load is simply started again
  task automatic load(input logic [31:0] img, input int n);
    int i;
    int t;
    @(posedge clk_i) request_b_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    request_b_o <= 1'b1;
    t = 0;
    // nothing is sent before the status line is seen high or 200 cycles pass
    while (status_line_i !== 1'b1 && t < 200) begin
      @(posedge clk_i);
      t++;
    end
    // one bit per clock, last one too, until completion
    for (i = n - 1; i >= 0 && complete_line_i !== 1'b1; i--) begin
      data_o <= img[i];
      repeat (4) @(posedge clk_i);
      data_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      data_clk_o <= 1'b0;
    end
    // released data line shows the inverse of its last value
    data_o <= ~data_o;
  endtask
endmodule

`default_nettype wire

/* File: tb/psc_loader_tb.sv */
// bench of the passive serial loader: power-on delay, apb register table,
// chain hand-over, error halt and restart, external halt of the chain.
// assumes the design's own assertions run alongside; shared lines are
// resolved here as open drain with pull-ups.
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.svh"

module psc_loader_tb;
  import psc_pkg::*;
  typedef struct packed {
    logic wr;
    logic [11:0] a;
    logic [31:0] wd;
    logic [31:0] rd;
    logic err;
  } psc_row_t;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, rd;
  logic pready_o, pslverr_o, err;
  logic [31:0] prdata_o;
  logic sel_i = 1'b0, chain_b = 1'b0, stat_pull = 1'b0;
  logic req_b, data_clk, sdata, st_b_o, st_oe, cd_o, cd_oe, ceo_b;
  logic io_en, pu_en, uclk = 1'b0, pu_sel_b = 1'b0;
  psc_state_t stage_o;
  // open drain: a line is low only where an enabled driver shows 0
  wire logic st_line = ~((st_oe & ~st_b_o) | stat_pull);
  wire logic cd_line = ~(cd_oe & ~cd_o);
  int n_fail = 0;
  int samples_checked = 0;
  psc_row_t rows [10] = '{
    '{1'b0, `PSC_OFS_CTRL, 32'h0, 32'(`PSC_CTRL_RST), 1'b0},
    '{1'b0, `PSC_OFS_IMAGE_BITS, 32'h0, `PSC_IMAGE_BITS_RST, 1'b0},
    '{1'b0, `PSC_OFS_STATUS, 32'h0, 32'h0000_0001, 1'b0},
    '{1'b1, `PSC_OFS_IMAGE_BITS, 32'h0000_0010, 32'h0, 1'b0},
    '{1'b0, `PSC_OFS_IMAGE_BITS, 32'h0, 32'h0000_0010, 1'b0},
    '{1'b1, `PSC_OFS_STATUS, 32'h0000_00FF, 32'h0, 1'b0},
    '{1'b0, `PSC_OFS_STATUS, 32'h0, 32'h0000_0001, 1'b0},
    '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1},
    '{1'b1, `PSC_OFS_CTRL, 32'h0000_0003, 32'h0, 1'b0},
    '{1'b0, `PSC_OFS_CTRL, 32'h0, 32'h0000_0003, 1'b0}
  };

  // 50 MHz bench clock
  always #10 clk_i = ~clk_i;

  psc_loader #(.POR_LONG_CYC(200), .POR_SHORT_CYC(50), .INIT_CYC(10)) DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o),
    .reset_delay_select_i(sel_i), .weak_pullup_select_b_i(pu_sel_b),
    .config_request_line_b_i(req_b), .config_status_line_b_i(st_line),
    .config_status_line_b_o(st_b_o), .config_status_line_b_oe_o(st_oe),
    .load_complete_line_i(cd_line), .load_complete_line_o(cd_o),
    .load_complete_line_oe_o(cd_oe), .config_data_clock_i(data_clk),
    .serial_config_data_i(sdata), .chain_enable_in_b_i(chain_b),
    .chain_enable_out_b_o(ceo_b), .user_startup_clock_i(uclk),
    .user_io_enable_o(io_en), .weak_pullup_en_o(pu_en), .stage_o(stage_o)
  );

  psc_host_model host (
    .clk_i(clk_i), .status_line_i(st_line), .complete_line_i(cd_line),
    .request_b_o(req_b), .data_clk_o(data_clk), .data_o(sdata)
  );

  task automatic conclude();
    $display("compares %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; the wait for pready is bounded
  task automatic apb(input psc_row_t r, output logic [31:0] d,
                     output logic e);
    int t;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= r.wr;
    paddr_i <= r.a;
    pwdata_i <= r.wd;
    @(posedge clk_i) penable_i <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (pready_o !== 1'b1 && t < 20);
    chk("pready", 32'h1, 32'(pready_o));
    d = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_stage(input psc_state_t st, input int lim);
    int t;
    t = 0;
    while (stage_o !== st && t < lim) begin
      @(posedge clk_i);
      t++;
    end
    chk("stage", 32'(st), 32'(stage_o));
  endtask

  // watchdog: the whole sequence needs far fewer cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    chk("por stage", 32'(psc_st_por), 32'(stage_o));
    chk("por status", 32'h0, 32'(st_line));
    rst_b_i <= 1'b1;
    repeat (150) @(posedge clk_i);
    chk("io during por", 32'h0, 32'(io_en));
    chk("long delay", 32'(psc_st_por), 32'(stage_o));
    wait_stage(psc_st_reset, 100);
    foreach (rows[i]) begin
      apb(rows[i], rd, err);
      chk("prdata", rows[i].rd, rd);
      chk("pslverr", 32'(rows[i].err), 32'(err));
    end
    // chain input high: the stream belongs to an earlier device
    chain_b <= 1'b1;
    host.load(32'h0000_A53C, 16);
    chk("chain held", 32'(psc_st_config), 32'(stage_o));
    chk("chain out idle", 32'h1, 32'(ceo_b));
    chk("pullup in config", 32'h1, 32'(pu_en));
    pu_sel_b <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("pullup deselected", 32'h0, 32'(pu_en));
    pu_sel_b <= 1'b0;
    chk("io in config", 32'h0, 32'(io_en));
    // another device pulls status low: whole chain back to reset
    stat_pull <= 1'b1;
    wait_stage(psc_st_reset, 20);
    stat_pull <= 1'b0;
    chain_b <= 1'b0;
    host.load(32'h0000_5A3C, 16);
    chk("error stage", 32'(psc_st_error), 32'(stage_o));
    chk("error status", 32'h0, 32'(st_line));
    chk("status drive", 32'h0, 32'(st_b_o));
    chk("done drive", 32'h0, 32'(cd_o));
    host.load(32'h0000_A53C, 16);
    chk("chain out done", 32'h0, 32'(ceo_b));
    wait_stage(psc_st_init, 20);
    chk("done line", 32'h1, 32'(cd_line));
    wait_stage(psc_st_user, 90);
    chk("io in user", 32'h1, 32'(io_en));
    chk("pullup in user", 32'h0, 32'(pu_en));
    // user start-up clock option without cable: init waits on that pin
    apb(psc_row_t'{1'b1, `PSC_OFS_CTRL, 32'h1, 32'h0, 1'b0}, rd, err);
    chk("ctrl write", 32'h0, 32'(err));
    host.load(32'h0000_A53C, 16);
    wait_stage(psc_st_init, 20);
    repeat (80) @(posedge clk_i);
    chk("init held", 32'(psc_st_init), 32'(stage_o));
    repeat (24) begin
      repeat (4) @(posedge clk_i);
      uclk <= ~uclk;
    end
    wait_stage(psc_st_user, 20);
    // second reset with the short delay selected
    sel_i <= 1'b1;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk("short delay", 32'(psc_st_por), 32'(stage_o));
    wait_stage(psc_st_reset, 30);
    conclude();
  end
endmodule

`default_nettype wire
